// file: cis_sequencer.sv
// Interrupt acknowledge sequencer with AXI4-Lite register slave
// Contract
// - Each external pin can request on falling, rising or both edges.
// - One active flag per level; return instruction clears serviced level.
// - Requests reach arbitration only when their enable bits allow.
// - Acknowledge sets one of four level flags and calls the vector.
// - The hardware call pushes the program counter, never the status word.
// - External and timer flags clear when the service routine starts.
// - Serial, sync and converter flags stay set for software to clear.
// - Service at instruction end unless request came in last seven periods.
// - The inserted call lasts two machine cycles.
// - At least three machine cycles from external request to service.
// - Extra wait during a four-cycle instruction stays within three cycles.
// - After return or enable/priority access, one more instruction runs; the code holds only after return.
// - Single-source latency lies between three and eight machine cycles.
// - Machine cycle is 12 periods with divide bit set, six otherwise.
// - No acknowledge while an equal or higher level is in service.
// - Higher level wins among simultaneous requests.
// - Fixed polling order resolves requests within one level.
// - Edge select has four bits and resets to falling edges only.
// - In level mode the external flag follows the sampled pin.
`timescale 1ns/1ps
module cis_sequencer import cis_pkg::*; #(
  parameter logic [15:0] VEC_BASE = 16'h0003,
  parameter logic [15:0] VEC_STRIDE = 16'h0008
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write
  input wire logic [AXI_ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [AXI_ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // External pins, active low
  input wire logic ext_pin_zero_n,
  input wire logic ext_pin_one_n,
  // Peripheral request flags
  input wire logic timer_zero_ovf_flag,
  input wire logic timer_one_ovf_flag,
  input wire logic [1:0] serial_rx_tx_flags,
  input wire logic display_vsync_flag,
  input wire logic display_hsync_flag,
  input wire logic even_field_flag,
  input wire logic line_marker_flag,
  input wire logic acq_vsync_flag,
  input wire logic acq_hsync_flag,
  input wire logic converter_done_flag,
  output logic timer_zero_ovf_clr,
  output logic timer_one_ovf_clr,
  // Instruction sequencer
  output logic mc_strobe,
  input wire logic instr_final_mc,
  input wire logic instr_holds_ack,
  input wire logic irq_return_instr_exec,
  output logic call_busy,
  output logic call_push_pc,
  output logic [15:0] call_addr,
  output logic [3:0] call_src,
  output logic call_done,
  output logic [NUM_LVL-1:0] level_active
);
  typedef struct packed {
    logic [CTRL_W-1:0] ctrl;
    logic [3:0] edge_sel;
    logic [ENABLE_W-1:0] enable;
    logic [NUM_SRC-1:0] prio_a;
    logic [NUM_SRC-1:0] prio_b;
    logic aw_got;
    logic [AXI_ADDR_W-1:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] phase;
    logic mc_end;
    logic snap_found;
    logic [3:0] snap_src;
    logic [1:0] snap_lvl;
    cis_seq_t seq;
    logic [NUM_LVL-1:0] active;
    logic [3:0] src;
    logic [15:0] addr;
    logic done;
    logic [1:0] tclr;
    logic [1:0] eclr;
  } cis_top_st_t;

  cis_top_st_t st_ff;
  cis_top_st_t nxt_st;

  cis_pin_if pin_bus ();
  cis_arb_if arb_bus ();

  logic [NUM_SRC-1:0] raw_req;
  logic [32:0] rd_ans;
  logic [32:0] wr_old;
  logic [31:0] wr_word;
  logic [3:0] mc_len;
  logic [NUM_LVL-1:0] irq_return_instr_clr;

  // Bit 32 flags a mapped offset, bits 31:0 the read value
  function automatic logic [32:0] reg_read(input cis_top_st_t s,
      input logic [AXI_ADDR_W-1:0] a, input logic [NUM_SRC-1:0] req);
    logic [32:0] r;
    r = {1'b1, 32'h0000_0000};
    case (a)
      OFS_CTRL: r[CTRL_W-1:0] = s.ctrl;
      OFS_EDGE: r[3:0] = s.edge_sel;
      OFS_ENABLE: r[ENABLE_W-1:0] = s.enable;
      OFS_PRIO_A: r[NUM_SRC-1:0] = s.prio_a;
      OFS_PRIO_B: r[NUM_SRC-1:0] = s.prio_b;
      OFS_STATUS: begin
        r[STATUS_ACT_LSB +: NUM_LVL] = s.active;
        r[STATUS_REQ_LSB +: NUM_SRC] = req;
        r[STATUS_BUSY_BIT] = (s.seq != SEQ_IDLE);
      end
      default: r = {1'b0, 32'h0000_0000};
    endcase
    return r;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[8*b +: 8] = data[8*b +: 8];
      end
    end
    return m;
  endfunction

  // Returns a one-hot mask of the highest set level
  function automatic logic [NUM_LVL-1:0] top_level(
      input logic [NUM_LVL-1:0] act);
    logic [NUM_LVL-1:0] m;
    m = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      if (act[l]) begin
        m = '0;
        m[l] = 1'b1;
      end
    end
    return m;
  endfunction

  assign raw_req = {converter_done_flag, acq_hsync_flag, acq_vsync_flag,
                    line_marker_flag, even_field_flag, display_hsync_flag,
                    display_vsync_flag, |serial_rx_tx_flags,
                    timer_one_ovf_flag, pin_bus.flag[1],
                    timer_zero_ovf_flag, pin_bus.flag[0]};

  assign pin_bus.pin_n = {ext_pin_one_n, ext_pin_zero_n};
  assign pin_bus.edge_mode = {st_ff.ctrl[CTRL_EXT1_EDGE_BIT],
                              st_ff.ctrl[CTRL_EXT0_EDGE_BIT]};
  assign pin_bus.edge_sel = st_ff.edge_sel;
  assign pin_bus.clr = st_ff.eclr;

  assign arb_bus.req = raw_req & st_ff.enable[NUM_SRC-1:0] &
      {NUM_SRC{st_ff.enable[ENABLE_GLOBAL_BIT]}};
  assign arb_bus.lvl_a = st_ff.prio_a;
  assign arb_bus.lvl_b = st_ff.prio_b;
  assign arb_bus.active = st_ff.active;

  cis_edge_det u_edge (
    .aclk(aclk),
    .aresetn(aresetn),
    .pins(pin_bus.det)
  );

  cis_arbiter u_arb (
    .aclk(aclk),
    .aresetn(aresetn),
    .arb(arb_bus.arb)
  );

  assign s_axi_awready = ~st_ff.aw_got & ~st_ff.bvalid;
  assign s_axi_wready = ~st_ff.w_got & ~st_ff.bvalid;
  assign s_axi_arready = ~st_ff.rvalid;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.done = 1'b0;
    nxt_st.tclr = 2'h0;
    nxt_st.eclr = 2'h0;
    rd_ans = reg_read(st_ff, s_axi_araddr, raw_req);
    wr_old = reg_read(st_ff, st_ff.aw_addr, raw_req);
    wr_word = merge(wr_old[31:0], st_ff.w_data, st_ff.w_strb);
    mc_len = st_ff.ctrl[CTRL_CDC_BIT] ? OSC_PER_MC_SLOW
                                      : OSC_PER_MC_FAST;
    irq_return_instr_clr = irq_return_instr_exec ? top_level(st_ff.active) : '0;

    // Write channel: address and data in either order
    if (s_axi_awvalid && s_axi_awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.w_data = s_axi_wdata;
      nxt_st.w_strb = s_axi_wstrb;
    end
    if (st_ff.aw_got && st_ff.w_got) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = wr_old[32] ? RESP_OKAY : RESP_SLVERR;
      case (st_ff.aw_addr)
        OFS_CTRL: nxt_st.ctrl = wr_word[CTRL_W-1:0];
        OFS_EDGE: nxt_st.edge_sel = wr_word[3:0];
        OFS_ENABLE: nxt_st.enable = wr_word[ENABLE_W-1:0];
        OFS_PRIO_A: nxt_st.prio_a = wr_word[NUM_SRC-1:0];
        OFS_PRIO_B: nxt_st.prio_b = wr_word[NUM_SRC-1:0];
        default: nxt_st.bvalid = 1'b1;
      endcase
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end

    // Read channel
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rdata = rd_ans[31:0];
      nxt_st.rresp = rd_ans[32] ? RESP_OKAY : RESP_SLVERR;
    end

    // Machine cycle timing; a change to the fast rate mid-cycle ends it early
    nxt_st.phase = (st_ff.phase >= mc_len - 4'h1) ? 4'h0
                                                  : st_ff.phase + 4'h1;
    nxt_st.mc_end = (nxt_st.phase == mc_len - 4'h1);

    // Later requests miss this instruction and wait for the next
    if (st_ff.phase == POLL_PHASE) begin
      nxt_st.snap_found = arb_bus.found;
      nxt_st.snap_src = arb_bus.src;
      nxt_st.snap_lvl = arb_bus.lvl;
    end

    nxt_st.active = st_ff.active & ~irq_return_instr_clr;

    case (st_ff.seq)
      SEQ_IDLE: begin
        // Only at an instruction boundary, so MUL/DIV bound the wait
        if (st_ff.mc_end && instr_final_mc && st_ff.snap_found &&
            !instr_holds_ack &&
            ((st_ff.active >> st_ff.snap_lvl) == 4'h0)) begin
          nxt_st.seq = SEQ_CALL_A;
          nxt_st.active[st_ff.snap_lvl] = 1'b1;
          nxt_st.src = st_ff.snap_src;
          nxt_st.addr = VEC_BASE + 16'(st_ff.snap_src) * VEC_STRIDE;
        end
      end
      SEQ_CALL_A: begin
        if (st_ff.mc_end) begin
          nxt_st.seq = SEQ_CALL_B;
        end
      end
      SEQ_CALL_B: begin
        if (st_ff.mc_end) begin
          nxt_st.seq = SEQ_IDLE;
          nxt_st.done = 1'b1;
          // Serial, sync and converter flags are left alone
          nxt_st.eclr[0] = (st_ff.src == 4'(SRC_EXT0));
          nxt_st.eclr[1] = (st_ff.src == 4'(SRC_EXT1));
          nxt_st.tclr[0] = (st_ff.src == 4'(SRC_TMR0));
          nxt_st.tclr[1] = (st_ff.src == 4'(SRC_TMR1));
        end
      end
      default: nxt_st.seq = SEQ_IDLE;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.ctrl <= CTRL_RST;
      st_ff.edge_sel <= EDGE_RST;
      st_ff.enable <= ENABLE_RST;
      st_ff.prio_a <= PRIO_RST;
      st_ff.prio_b <= PRIO_RST;
      st_ff.seq <= SEQ_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;
  assign mc_strobe = st_ff.mc_end;
  assign call_busy = (st_ff.seq != SEQ_IDLE);
  // No status word push exists on this port
  assign call_push_pc = (st_ff.seq != SEQ_IDLE);
  assign call_addr = st_ff.addr;
  assign call_src = st_ff.src;
  assign call_done = st_ff.done;
  assign timer_zero_ovf_clr = st_ff.tclr[0];
  assign timer_one_ovf_clr = st_ff.tclr[1];
  assign level_active = st_ff.active;
endmodule

// file: cis_pkg.sv
// Shared constants and types of the interrupt sequencer
package cis_pkg;
  // Sources in polling order, index 0 polled first
  localparam int NUM_SRC = 12;
  localparam int NUM_LVL = 4;
  localparam int SRC_EXT0 = 0;
  localparam int SRC_TMR0 = 1;
  localparam int SRC_EXT1 = 2;
  localparam int SRC_TMR1 = 3;
  localparam int SRC_SER = 4;
  localparam int SRC_ADC = 11;

  // Register bus
  localparam int AXI_ADDR_W = 8;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_EDGE = 8'h04;
  localparam logic [7:0] OFS_ENABLE = 8'h08;
  localparam logic [7:0] OFS_PRIO_A = 8'h0C;
  localparam logic [7:0] OFS_PRIO_B = 8'h10;
  localparam logic [7:0] OFS_STATUS = 8'h14;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Control register fields
  localparam int CTRL_W = 3;
  localparam int CTRL_CDC_BIT = 0;
  localparam int CTRL_EXT0_EDGE_BIT = 1;
  localparam int CTRL_EXT1_EDGE_BIT = 2;
  localparam logic [CTRL_W-1:0] CTRL_RST = 3'h1;

  // Edge select fields, two bits per pin
  localparam int EDGE_FALL_OFS = 0;
  localparam int EDGE_RISE_OFS = 1;
  localparam logic [3:0] EDGE_RST = 4'h5;

  // Enable register fields
  localparam int ENABLE_W = 16;
  localparam int ENABLE_GLOBAL_BIT = 15;
  localparam logic [ENABLE_W-1:0] ENABLE_RST = 16'h0000;
  localparam logic [NUM_SRC-1:0] PRIO_RST = 12'h000;

  // Status register fields
  localparam int STATUS_ACT_LSB = 0;
  localparam int STATUS_REQ_LSB = 4;
  localparam int STATUS_BUSY_BIT = 16;

  // Machine cycle timing in oscillator periods
  localparam logic [3:0] OSC_PER_MC_SLOW = 4'hC;
  localparam logic [3:0] OSC_PER_MC_FAST = 4'h6;
  localparam logic [3:0] POLL_LEAD_OSC = 4'h7;
  // Same phase serves both rates: 12-7 in-cycle, 2*6-7 one cycle early
  localparam logic [3:0] POLL_PHASE = OSC_PER_MC_SLOW - POLL_LEAD_OSC;
  localparam int CALL_MC = 2;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_CALL_A = 3'b010,
    SEQ_CALL_B = 3'b100
  } cis_seq_t;
endpackage

// file: cis_if.sv
// Internal carriers between the sequencer and its helpers
`timescale 1ns/1ps
interface cis_pin_if;
  logic [1:0] pin_n;
  logic [1:0] edge_mode;
  logic [3:0] edge_sel;
  logic [1:0] clr;
  logic [1:0] flag;
  modport det (input pin_n, edge_mode, edge_sel, clr, output flag);
  modport ctl (output pin_n, edge_mode, edge_sel, clr, input flag);
endinterface

interface cis_arb_if import cis_pkg::*; ();
  logic [NUM_SRC-1:0] req;
  logic [NUM_SRC-1:0] lvl_a;
  logic [NUM_SRC-1:0] lvl_b;
  logic [NUM_LVL-1:0] active;
  logic found;
  logic [3:0] src;
  logic [1:0] lvl;
  modport arb (input req, lvl_a, lvl_b, active, output found, src, lvl);
  modport ctl (output req, lvl_a, lvl_b, active, input found, src, lvl);
endinterface

// file: cis_edge_det.sv
// Pin synchroniser and edge or level detector for both external pins
`timescale 1ns/1ps
module cis_edge_det import cis_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Pin side
  cis_pin_if.det pins
);
  typedef struct packed {
    logic [1:0] meta;
    logic [1:0] sync;
    logic [1:0] prev;
    logic [1:0] flag;
  } cis_edge_st_t;

  cis_edge_st_t st_ff;
  cis_edge_st_t nxt_st;
  logic [1:0] fall;
  logic [1:0] rise;
  logic [1:0] hit;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.meta = pins.pin_n;
    nxt_st.sync = st_ff.meta;
    nxt_st.prev = st_ff.sync;
    for (int i = 0; i < 2; i++) begin
      fall[i] = st_ff.prev[i] & ~st_ff.sync[i];
      rise[i] = ~st_ff.prev[i] & st_ff.sync[i];
      hit[i] = (fall[i] & pins.edge_sel[2*i+EDGE_FALL_OFS]) |
               (rise[i] & pins.edge_sel[2*i+EDGE_RISE_OFS]);
      if (pins.edge_mode[i]) begin
        // Edge seen in the clearing cycle still wins
        if (hit[i]) begin
          nxt_st.flag[i] = 1'b1;
        end else if (pins.clr[i]) begin
          nxt_st.flag[i] = 1'b0;
        end
      end else begin
        nxt_st.flag[i] = ~st_ff.sync[i];
      end
    end
  end

  // Pins idle high, so no false edge straight after reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.meta <= 2'h3;
      st_ff.sync <= 2'h3;
      st_ff.prev <= 2'h3;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign pins.flag = st_ff.flag;
endmodule

// file: cis_arbiter.sv
// Level and polling-order arbiter with nesting block
`timescale 1ns/1ps
module cis_arbiter import cis_pkg::*; (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Request side
  cis_arb_if.arb arb
);
  typedef struct packed {
    logic found;
    logic [3:0] src;
    logic [1:0] lvl;
  } cis_arb_st_t;

  cis_arb_st_t st_ff;
  cis_arb_st_t nxt_st;

  // Level l is open only while no level at or above it is active
  function automatic logic [NUM_LVL-1:0] lvl_open(
      input logic [NUM_LVL-1:0] act);
    logic [NUM_LVL-1:0] res;
    res = '1;
    for (int l = 0; l < NUM_LVL; l++) begin
      for (int k = l; k < NUM_LVL; k++) begin
        if (act[k]) begin
          res[l] = 1'b0;
        end
      end
    end
    return res;
  endfunction

  logic [NUM_LVL-1:0] open_lvl;

  // Later writes win: highest level, then lowest polling index
  always_comb begin
    open_lvl = lvl_open(arb.active);
    nxt_st = '0;
    for (int l = 0; l < NUM_LVL; l++) begin
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
        if (arb.req[i] && open_lvl[l] &&
            ({arb.lvl_b[i], arb.lvl_a[i]} == 2'(l))) begin
          nxt_st.found = 1'b1;
          nxt_st.src = 4'(i);
          nxt_st.lvl = 2'(l);
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign arb.found = st_ff.found;
  assign arb.src = st_ff.src;
  assign arb.lvl = st_ff.lvl;
endmodule

// file: cis_core_model.sv
// Instruction sequencer model on the core side of the sequencer
`timescale 1ns/1ps
module cis_core_model (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Bench control
  input wire logic [2:0] instr_len,
  input wire logic irq_return_instr_cmd,
  // Sequencer link
  input wire logic mc_strobe,
  input wire logic call_busy,
  output logic instr_final_mc,
  output logic instr_holds_ack,
  output logic irq_return_instr_exec
);
  logic [2:0] cnt_ff;
  logic pend_ff;
  logic ends;
  // The call itself stands in for an instruction while it runs
  assign instr_final_mc = !call_busy && cnt_ff == instr_len - 3'h1;
  assign ends = mc_strobe && instr_final_mc;
  // Return in flight holds off the ack
  assign instr_holds_ack = pend_ff;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 3'h0;
      pend_ff <= 1'b0;
      irq_return_instr_exec <= 1'b0;
    end else begin
      irq_return_instr_exec <= pend_ff && ends;
      pend_ff <= irq_return_instr_cmd || (pend_ff && !ends);
      cnt_ff <= (call_busy || ends) ? 3'h0 : cnt_ff + {2'h0, mc_strobe};
    end
  end
endmodule

// file: cis_sequencer_chk.sv
// Port checker for the interrupt sequencer
`timescale 1ns/1ps
module cis_chk import cis_pkg::*; #(
  parameter logic [15:0] VEC_BASE = 16'h0003,
  parameter logic [15:0] VEC_STRIDE = 16'h0008
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Core link
  input wire logic mc_strobe,
  input wire logic instr_final_mc,
  input wire logic instr_holds_ack,
  input wire logic irq_return_instr_exec,
  input wire logic call_busy,
  input wire logic call_push_pc,
  input wire logic [15:0] call_addr,
  input wire logic [3:0] call_src,
  input wire logic call_done,
  input wire logic [NUM_LVL-1:0] level_active,
  // Timer clears
  input wire logic timer_zero_ovf_clr,
  input wire logic timer_one_ovf_clr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [1:0] strb_ff;
  logic [3:0] lvl_ff;
  logic [3:0] new_lvl;
  logic [3:0] top_gone;
  assign new_lvl = level_active & ~lvl_ff;
  // Highest active level removed
  always_comb begin
    top_gone = level_active;
    for (int i = 0; i < 4; i++) begin
      if (level_active[i]) begin
        top_gone = level_active & ~(4'h1 << i);
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      strb_ff <= 2'h0;
      lvl_ff <= 4'h0;
    end else begin
      strb_ff <= call_busy ? strb_ff + {1'b0, mc_strobe} : 2'h0;
      lvl_ff <= level_active;
    end
  end
  a_ack_at_end: assert property (
    $rose(call_busy) |-> $past(mc_strobe) && $past(instr_final_mc)
      && !$past(instr_holds_ack)) else $error("ack off instruction end");
  a_push_pc_only: assert property (
    call_push_pc == call_busy) else $error("push differs from call");
  a_call_two_mc: assert property (
    $fell(call_busy) |-> strb_ff == 2'(CALL_MC)) else $error("call length");
  a_done_follows: assert property (
    call_done |-> !call_busy && $past(call_busy)) else $error("done early");
  a_one_level: assert property (
    $rose(call_busy) |-> $onehot(new_lvl)) else $error("level set count");
  a_nest_block: assert property (
    $rose(call_busy) |-> lvl_ff < new_lvl) else $error("nesting breach");
  a_vector_addr: assert property (
    $rose(call_busy) |-> call_addr == VEC_BASE + VEC_STRIDE
      * {12'h000, call_src}) else $error("vector address");
  a_irq_return_instr_drop: assert property (
    irq_return_instr_exec && !mc_strobe |=> level_active == $past(top_gone))
    else $error("return level clear");
  a_tmr_zero_clr: assert property (
    timer_zero_ovf_clr == (call_done && call_src == 4'(SRC_TMR0)))
    else $error("timer zero clear");
  a_tmr_one_clr: assert property (
    timer_one_ovf_clr == (call_done && call_src == 4'(SRC_TMR1)))
    else $error("timer one clear");
  c_ack: cover property ($rose(call_busy));
  c_irq_return_instr: cover property (irq_return_instr_exec);
  c_tmr_clr: cover property (timer_zero_ovf_clr);
endmodule

bind cis_sequencer cis_chk #(.VEC_BASE(VEC_BASE), .VEC_STRIDE(VEC_STRIDE))
  u_chk (.aclk(aclk), .aresetn(aresetn), .mc_strobe(mc_strobe),
  .instr_final_mc(instr_final_mc), .instr_holds_ack(instr_holds_ack),
  .irq_return_instr_exec(irq_return_instr_exec), .call_busy(call_busy),
  .call_push_pc(call_push_pc), .call_addr(call_addr),
  .call_src(call_src), .call_done(call_done),
  .level_active(level_active), .timer_zero_ovf_clr(timer_zero_ovf_clr),
  .timer_one_ovf_clr(timer_one_ovf_clr));

// file: tb_top.sv
// Self-checking bench for the interrupt sequencer
`timescale 1ns/1ps
module tb_top import cis_pkg::*; ;
  localparam logic [15:0] VB = 16'h0003;
  localparam logic [15:0] VS = 16'h0008;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] awaddr = 8'h00;
  logic [7:0] araddr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
  // Answers are always accepted at once
  logic bready = 1'b1, rready = 1'b1;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata;
  logic pin0_n = 1'b1, pin1_n = 1'b1;
  logic [11:0] flg = 12'h000;
  logic [2:0] ilen = 3'h1;
  logic irq_return_instr_cmd = 1'b0;
  logic t0_clr, t1_clr, strobe, fin, hold, irq_return_instr, busy, push, done;
  logic [15:0] caddr;
  logic [3:0] csrc, lvl;
  int mismatches = 0;
  int checks_done = 0;
  int lat, k, s;

  initial begin
    forever #50 aclk = ~aclk;
  end

  cis_sequencer #(.VEC_BASE(VB), .VEC_STRIDE(VS)) dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .ext_pin_zero_n(pin0_n), .ext_pin_one_n(pin1_n),
    .timer_zero_ovf_flag(flg[1]), .timer_one_ovf_flag(flg[3]),
    .serial_rx_tx_flags({flg[4], flg[0]}), .display_vsync_flag(flg[5]),
    .display_hsync_flag(flg[6]), .even_field_flag(flg[7]),
    .line_marker_flag(flg[8]), .acq_vsync_flag(flg[9]),
    .acq_hsync_flag(flg[10]), .converter_done_flag(flg[11]),
    .timer_zero_ovf_clr(t0_clr), .timer_one_ovf_clr(t1_clr),
    .mc_strobe(strobe), .instr_final_mc(fin), .instr_holds_ack(hold),
    .irq_return_instr_exec(irq_return_instr), .call_busy(busy), .call_push_pc(push),
    .call_addr(caddr), .call_src(csrc), .call_done(done),
    .level_active(lvl));

  cis_core_model core (.aclk(aclk), .aresetn(aresetn), .instr_len(ilen),
    .irq_return_instr_cmd(irq_return_instr_cmd), .mc_strobe(strobe), .call_busy(busy),
    .instr_final_mc(fin), .instr_holds_ack(hold), .irq_return_instr_exec(irq_return_instr));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task give_verdict();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  task tmo();
    chk(32'h0, 32'h1);
    give_verdict();
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 50) tmo();
    chk(bresp, er);
  endtask

  task rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    int n;
    araddr <= a;
    arvalid <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 50) tmo();
    chk(rdata, ed);
    chk(rresp, er);
  endtask

  task period(input int p);
    int n;
    for (n = 0; n < 30 && !strobe; n++) @(posedge aclk);
    @(posedge aclk);
    for (n = 1; n < 30 && !strobe; n++) @(posedge aclk);
    chk(n, p);
  endtask

  // Waits for one service, checks it, then returns from it
  task serve(input int s, input logic [3:0] lv);
    int n;
    for (n = 0; n < 3000 && !busy; n++) @(posedge aclk);
    if (n == 3000) tmo();
    lat = n;
    chk(csrc, s);
    chk(caddr, VB + VS * s[15:0]);
    chk(lvl, lv);
    chk(push, 1'b1);
    for (n = 0; n < 100 && !done; n++) @(posedge aclk);
    if (n == 100) tmo();
    // Timer clear pulse must stand with the done pulse
    chk({t1_clr, t0_clr}, {30'h0, s == SRC_TMR1, s == SRC_TMR0});
    lat += n;
    repeat (40) @(posedge aclk);
    chk(busy, 1'b0);
    // Timers and software drop their flags; pins have no bench flag
    if (s != SRC_EXT0 && s != SRC_EXT1) flg[s] <= 1'b0;
    irq_return_instr_cmd <= 1'b1;
    @(posedge aclk);
    irq_return_instr_cmd <= 1'b0;
    for (n = 0; n < 100 && lvl != 4'h0; n++) @(posedge aclk);
    chk(lvl, 4'h0);
  endtask

  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(OFS_CTRL, 32'h0000_0001, RESP_OKAY);
    rd(OFS_EDGE, 32'h0000_0005, RESP_OKAY);
    rd(OFS_ENABLE, 32'h0000_0000, RESP_OKAY);
    rd(OFS_PRIO_B, 32'h0000_0000, RESP_OKAY);
    rd(8'h18, 32'h0000_0000, RESP_SLVERR);
    wr(8'h18, 32'h0000_000F, RESP_SLVERR);
    period(12);
    $display("test registers done");
    wr(OFS_ENABLE, 32'h0000_8FFF, RESP_OKAY);
    flg <= 12'hFFA;
    for (s = 1; s < 12; s++) begin
      if (s != 2) serve(s, 4'h1);
    end
    $display("test polling done");
    wr(OFS_PRIO_A, 32'h0000_0808, RESP_OKAY);
    wr(OFS_PRIO_B, 32'h0000_0800, RESP_OKAY);
    flg <= 12'h80A;
    serve(11, 4'h8);
    serve(3, 4'h2);
    serve(1, 4'h1);
    $display("test levels done");
    wr(OFS_CTRL, 32'h0000_0007, RESP_OKAY);
    wr(OFS_EDGE, 32'h0000_000B, RESP_OKAY);
    for (k = 0; k < 4; k++) begin
      repeat (k * 3 + 1) @(posedge aclk);
      pin0_n <= ~pin0_n;
      serve(0, 4'h1);
      chk(lat >= 36 && lat < 96, 1'b1);
    end
    pin1_n <= 1'b0;
    repeat (100) @(posedge aclk);
    chk(busy, 1'b0);
    pin1_n <= 1'b1;
    serve(2, 4'h1);
    $display("test edges done");
    wr(OFS_ENABLE, 32'h0000_0000, RESP_OKAY);
    wr(OFS_CTRL, 32'h0000_0003, RESP_OKAY);
    pin1_n <= 1'b0;
    repeat (10) @(posedge aclk);
    rd(OFS_STATUS, 32'h0000_0040, RESP_OKAY);
    chk(busy, 1'b0);
    pin1_n <= 1'b1;
    repeat (10) @(posedge aclk);
    rd(OFS_STATUS, 32'h0000_0000, RESP_OKAY);
    $display("test level mode done");
    wr(OFS_CTRL, 32'h0000_0000, RESP_OKAY);
    period(6);
    ilen <= 3'h4;
    wr(OFS_ENABLE, 32'h0000_8002, RESP_OKAY);
    flg[1] <= 1'b1;
    serve(1, 4'h1);
    chk(lat < 48, 1'b1);
    $display("test fast done");
    give_verdict();
  end
endmodule
